// file: core/pts_pkg.sv
package pts_pkg;
    // Register byte addresses (word aligned)
    localparam logic [3:0] ADDR_COUNT = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_FLAG = 4'hc;
    localparam logic [3:0] ADDR_ENABLE = 4'h0;
    localparam logic [3:0] ADDR_ENABLE_B = 4'h0;
    localparam logic [4:0] ADDR_ENABLE_FULL = 5'h10;
    localparam logic [4:0] ADDR_COUNT_FULL = 5'h00;
    localparam logic [4:0] ADDR_PERIOD_FULL = 5'h04;
    localparam logic [4:0] ADDR_CONTROL_FULL = 5'h08;
    localparam logic [4:0] ADDR_FLAG_FULL = 5'h0c;
    // Control field positions
    localparam int CTL_PRE_LSB = 0;
    localparam int CTL_RUN_BIT = 2;
    localparam int CTL_POST_LSB = 3;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h7f;
    // Flag / enable field positions
    localparam int FLAG_MATCH_BIT = 0;
    // Reset values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Instruction clock = system clock / 4
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    // Prescale terminal counts (ratio minus one)
    localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
    localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
    localparam logic [3:0] PRE_LAST_DIV16 = 4'hf;
endpackage

// file: core/pts_prescaler.sv
`timescale 1ns/100ps
// Instruction clock divider plus selectable prescaler
module pts_prescaler
    import pts_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] sel,
    // Output
    output logic tick
);
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic [3:0] pre_reg;
    logic [3:0] pre_next;
    logic [3:0] last;
    logic instr_tick;

    function automatic logic [3:0] pre_last(input logic [1:0] s);
        if (s[1]) begin
            return PRE_LAST_DIV16;
        end else if (s[0]) begin
            return PRE_LAST_DIV4;
        end
        return PRE_LAST_DIV1;
    endfunction

    always_comb begin
        last = pre_last(sel);
        instr_tick = (phase_reg == INSTR_DIV_LAST);
        phase_next = phase_reg + 2'h1;
        pre_next = pre_reg;
        tick = 1'b0;
        if (clear) begin
            pre_next = 4'h0;
        end else if (run && instr_tick) begin
            if (pre_reg >= last) begin
                pre_next = 4'h0;
                tick = 1'b1;
            end else begin
                pre_next = pre_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= 2'h0;
            pre_reg <= 4'h0;
        end else begin
            phase_reg <= phase_next;
            pre_reg <= pre_next;
        end
    end
endmodule

// file: core/pts_timer.sv
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
module pts_timer
    import pts_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Interrupt
    output logic irq
);
    // ****************************************
    // Bus decode
    // ****************************************
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic req;
    logic wr_lane0;
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic wr_flag;
    logic wr_enable;

    // Only the low byte lane carries register data
    assign req = cyc_i && stb_i && !ack_reg;
    assign wr_lane0 = req && we_i && sel_i[0];
    assign wr_count = wr_lane0 && (adr_i == ADDR_COUNT_FULL);
    assign wr_period = wr_lane0 && (adr_i == ADDR_PERIOD_FULL);
    assign wr_control = wr_lane0 && (adr_i == ADDR_CONTROL_FULL);
    assign wr_flag = wr_lane0 && (adr_i == ADDR_FLAG_FULL);
    assign wr_enable = wr_lane0 && (adr_i == ADDR_ENABLE_FULL);

    // ****************************************
    // Timer state
    // ****************************************
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] period_reg;
    logic [7:0] period_next;
    logic [6:0] control_reg;
    logic [6:0] control_next;
    logic [3:0] post_reg;
    logic [3:0] post_next;
    logic flag_reg;
    logic flag_next;
    logic enable_reg;
    logic enable_next;
    logic tick;
    logic match;
    logic post_out;
    logic scaler_clear;

    assign scaler_clear = wr_count || wr_control;

    pts_prescaler u_pre (
        .clk(clk),
        .rst(rst),
        .run(control_reg[CTL_RUN_BIT]),
        .clear(scaler_clear),
        .sel(control_reg[CTL_PRE_LSB +: 2]),
        .tick(tick)
    );

    always_comb begin
        match = (count_reg == period_reg);
        count_next = count_reg;
        post_next = post_reg;
        post_out = 1'b0;
        period_next = period_reg;
        control_next = control_reg;
        flag_next = flag_reg;
        enable_next = enable_reg;
        if (tick) begin
            if (match) begin
                count_next = 8'h00;
                if (post_reg >= control_reg[CTL_POST_LSB +: 4]) begin
                    post_next = 4'h0;
                    post_out = 1'b1;
                end else begin
                    post_next = post_reg + 4'h1;
                end
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
        if (wr_count) begin
            count_next = dat_i[7:0];
        end
        if (scaler_clear) begin
            post_next = 4'h0;
        end
        if (wr_period) begin
            period_next = dat_i[7:0];
        end
        if (wr_control) begin
            control_next = dat_i[6:0] & CTL_WRITE_MASK[6:0];
        end
        if (wr_enable) begin
            enable_next = dat_i[FLAG_MATCH_BIT];
        end
        // Write one clears; a same-cycle set wins
        if (wr_flag && dat_i[FLAG_MATCH_BIT]) begin
            flag_next = 1'b0;
        end
        if (post_out) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= COUNT_RESET;
            period_reg <= PERIOD_RESET;
            control_reg <= CONTROL_RESET[6:0];
            post_reg <= 4'h0;
            flag_reg <= 1'b0;
            enable_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            period_reg <= period_next;
            control_reg <= control_next;
            post_reg <= post_next;
            flag_reg <= flag_next;
            enable_reg <= enable_next;
        end
    end

    assign irq = flag_reg && enable_reg;

    // ****************************************
    // Bus answer
    // ****************************************
    always_comb begin
        ack_next = req;
        rdata_next = rdata_reg;
        if (req) begin
            unique case (adr_i)
                ADDR_COUNT_FULL: rdata_next = {24'h0, count_reg};
                ADDR_PERIOD_FULL: rdata_next = {24'h0, period_reg};
                ADDR_CONTROL_FULL: rdata_next = {25'h0, control_reg};
                ADDR_FLAG_FULL: rdata_next = {31'h0, flag_reg};
                ADDR_ENABLE_FULL: rdata_next = {31'h0, enable_reg};
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = rdata_reg;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_tick_at_match;
        tick && match && !wr_count;
    endsequence

    property p_wrap;
        @(posedge clk) disable iff (rst) s_tick_at_match |=> count_reg == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap");

    property p_inc;
        @(posedge clk) disable iff (rst)
        tick && !match && !wr_count |=> count_reg == $past(count_reg) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not advance");

    property p_hold;
        @(posedge clk) disable iff (rst)
        !tick && !wr_count |=> $stable(count_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without tick");

    property p_stop;
        @(posedge clk) disable iff (rst) !control_reg[CTL_RUN_BIT] |-> !tick;
    endproperty
    a_stop: assert property (p_stop) else $error("tick while halted");

    property p_flag_set;
        @(posedge clk) disable iff (rst) post_out |=> flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_sticky;
        @(posedge clk) disable iff (rst) flag_reg && !wr_flag |=> flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_irq;
        @(posedge clk) disable iff (rst) wr_enable && !dat_i[FLAG_MATCH_BIT] |=> !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_post_clr;
        @(posedge clk) disable iff (rst) scaler_clear |=> post_reg == 4'h0;
    endproperty
    a_post_clr: assert property (p_post_clr) else $error("postscaler not cleared");

    property p_period_wr;
        @(posedge clk) disable iff (rst) wr_period |=> period_reg == $past(dat_i[7:0]);
    endproperty
    a_period_wr: assert property (p_period_wr) else $error("period write lost");

    property p_post_ratio;
        @(posedge clk) disable iff (rst)
        post_out |-> post_reg == control_reg[CTL_POST_LSB +: 4];
    endproperty
    a_post_ratio: assert property (p_post_ratio) else $error("bad postscale");

    sequence s_quiet3;
        !tick [*3];
    endsequence

    property p_tick_gap;
        @(posedge clk) disable iff (rst) tick |=> s_quiet3;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");

    property p_clr_no_tick;
        @(posedge clk) disable iff (rst) scaler_clear |-> !tick;
    endproperty
    a_clr_no_tick: assert property (p_clr_no_tick) else $error("tick in clear");

    property p_ctl_keep;
        @(posedge clk) disable iff (rst) wr_control |=> $stable(count_reg);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep) else $error("count moved");

    property p_count_wr;
        @(posedge clk) disable iff (rst) wr_count |=> count_reg == $past(dat_i[7:0]);
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("count write lost");

    sequence s_bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence

    property p_ack_answer;
        @(posedge clk) disable iff (rst) s_bus_req |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bad ack");

    sequence s_count_read;
        cyc_i && stb_i && !ack_o && !we_i && (adr_i == ADDR_COUNT_FULL);
    endsequence

    property p_count_rd;
        @(posedge clk) disable iff (rst) s_count_read |=> dat_o == {24'h0, $past(count_reg)};
    endproperty
    a_count_rd: assert property (p_count_rd) else $error("bad count read");

    property p_period_keep;
        @(posedge clk) disable iff (rst) !wr_period |=> $stable(period_reg);
    endproperty
    a_period_keep: assert property (p_period_keep) else $error("period moved");

    property p_post_src;
        @(posedge clk) disable iff (rst) post_out |-> tick && match;
    endproperty
    a_post_src: assert property (p_post_src) else $error("stray post out");

    property p_post_adv;
        @(posedge clk) disable iff (rst)
        tick && match && !post_out |=> post_reg == $past(post_reg) + 4'h1;
    endproperty
    a_post_adv: assert property (p_post_adv) else $error("post not advanced");

    property p_post_still;
        @(posedge clk) disable iff (rst)
        !(tick && match) && !scaler_clear |=> $stable(post_reg);
    endproperty
    a_post_still: assert property (p_post_still) else $error("post moved");

    property p_flag_quiet;
        @(posedge clk) disable iff (rst) !flag_reg && !post_out |=> !flag_reg;
    endproperty
    a_flag_quiet: assert property (p_flag_quiet) else $error("flag set alone");

    property p_flag_clr;
        @(posedge clk) disable iff (rst)
        wr_flag && dat_i[FLAG_MATCH_BIT] && !post_out |=> !flag_reg;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
endmodule

// file: verification/tb_pts_timer.sv
`timescale 1ns/100ps
module tb_pts_timer;
    import pts_pkg::*;
    // ****************
    // Stimulus and design
    // ****************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'hf;
    logic [3:0] sel_v = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack_o;
    logic irq;
    logic [15:0] seed = 16'ha102;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    int mdl [5] = '{0, 8'hff, 0, 0, 0};
    int msk [5] = '{8'hff, 8'hff, 8'h7f, 1, 1};
    int n;
    int per;
    int post;
    int pre;
    int expc;

    always #20 clk = ~clk;

    pts_timer u_pts_timer (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .irq(irq));

    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Long enough for the slowest prescale and postscale run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            wrap_up();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_win(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo + 8);
        end
    endtask

    task wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= sel_v;
        dat <= {24'h0, d};
        do begin
            @(posedge clk);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 50) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, ack_o, 1'b1);
        end
    endtask

    // Model follows every accepted write
    task wr(input logic [4:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
        if (sel_v[0] && a[4:2] < 5) begin
            if (a[4:2] == 3) begin
                mdl[3] = mdl[3] & ~int'(d[0]);
            end else begin
                mdl[a[4:2]] = d & msk[a[4:2]];
            end
        end
    endtask

    task rdc(input logic [4:0] a);
        wb(1'b0, a, 8'h00);
        chk(rd, (a[4:2] < 5) ? mdl[a[4:2]] : 0);
    endtask

    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rdc(5'(i * 4));
        end
        seed = lfsr(seed);
        wr(ADDR_COUNT_FULL, seed[7:0]);
        wr(ADDR_PERIOD_FULL, seed[15:8]);
        rdc(ADDR_COUNT_FULL);
        rdc(ADDR_PERIOD_FULL);
        sel_v = 4'he;
        wr(ADDR_COUNT_FULL, ~seed[7:0]);
        sel_v = 4'hf;
        rdc(ADDR_COUNT_FULL);
        wr(5'h14, 8'h5a);
        rdc(5'h14);
        // Run bit left clear so the count must hold still
        wr(ADDR_CONTROL_FULL, 8'hfb);
        rdc(ADDR_CONTROL_FULL);
        rdc(ADDR_COUNT_FULL);
        repeat (200) @(posedge clk);
        rdc(ADDR_COUNT_FULL);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            per = seed[2:0];
            post = seed[6:3];
            pre = (k == 0) ? 1 : (k == 1) ? 4 : 16;
            wr(ADDR_PERIOD_FULL, 8'(per));
            wr(ADDR_COUNT_FULL, 8'h00);
            wr(ADDR_FLAG_FULL, 8'h01);
            wr(ADDR_ENABLE_FULL, 8'h01);
            wr(ADDR_CONTROL_FULL, {1'b0, 4'(post), 1'b1, 2'(k)});
            n = 0;
            while (irq !== 1'b1 && n < 20000) begin
                @(posedge clk);
                n++;
            end
            // Free-running divide by four leaves a few cycles of phase slack
            expc = 4 * pre * (per + 1) * (post + 1);
            chk_win(n, expc - 8, expc + 8);
            wr(ADDR_ENABLE_FULL, 8'h00);
            @(negedge clk);
            chk(irq, 1'b0);
            mdl[3] = 1;
            rdc(ADDR_FLAG_FULL);
            wr(ADDR_CONTROL_FULL, 8'h00);
            wr(ADDR_FLAG_FULL, 8'h01);
            rdc(ADDR_FLAG_FULL);
            wr(ADDR_ENABLE_FULL, 8'h01);
            @(negedge clk);
            chk(irq, 1'b0);
        end
        // Mid-run reset must restore every register and drop the interrupt
        wr(ADDR_PERIOD_FULL, 8'h03);
        wr(ADDR_COUNT_FULL, 8'h00);
        wr(ADDR_CONTROL_FULL, 8'h04);
        repeat (40) @(posedge clk);
        @(negedge clk);
        chk(irq, 1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mdl = '{0, 8'hff, 0, 0, 0};
        chk(irq, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rdc(5'(i * 4));
        end
        wrap_up();
    end
endmodule
